// ===== fll_pkg.sv
/*
  constants for the fast link-loss monitor and strap configuration latch:
  management register offsets, field positions, reset values, window timing.
  assumes a 40 MHz system clock and a 16-bit management register port.
*/
package fll_pkg;

  // management register offsets
  localparam logic [15:0] OFF_CONTROL_THREE = 16'h000b;
  localparam logic [15:0] OFF_FAULT_STATUS  = 16'h000f;
  localparam logic [15:0] OFF_CONFIG_ONE    = 16'h0117;
  localparam logic [15:0] OFF_CONFIG_TWO    = 16'h0131;

  // criterion field positions, shared by control_three and the status register
  localparam int BIT_RX_ERR  = 0;
  localparam int BIT_CODE    = 1;
  localparam int BIT_SNR     = 2;
  localparam int BIT_ENERGY  = 3;
  localparam int BIT_DESCR   = 10;

  // enable field mask of control_three
  localparam logic [15:0] CRIT_MASK = 16'h040f;

  // reset values
  localparam logic [15:0] CONTROL_THREE_RST = 16'h0000;
  localparam logic [15:0] CONFIG_ONE_RST    = 16'h0000;
  localparam logic [15:0] CONFIG_TWO_RST    = 16'h0000;
  localparam logic [15:0] FAULT_STATUS_RST  = 16'h0000;

  // observation window, longest time so rounded down
  localparam int CLK_PERIOD_NS = 25;
  localparam int WINDOW_NS     = 10000;
  localparam int WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS;
  localparam int WIN_W         = 9;

  // event thresholds per counting criterion: rx error, code error, low snr
  localparam int NUM_COUNTED = 3;
  localparam int THR_RX_ERR  = 32;
  localparam int THR_CODE    = 20;
  localparam int THR_SNR     = 20;
  localparam int CNT_W       = 6;

  // strap capture: synchroniser depth, cycles to wait after reset release
  localparam int          SYNC_STAGES = 2;
  localparam logic [1:0]  CAPTURE_CYC = 2'h2;

  // strap defaults (level of the internal pull)
  localparam logic [2:0]  ADDR_STRAP_DEF = 3'h0;
  localparam logic        STRAP_DEF_ZERO = 1'b0;

  // clock output selection on the carrier-sense / collision pins
  typedef enum logic [1:0] {
    FLL_CLK_OFF = 2'h0,
    FLL_CLK_25  = 2'h1,
    FLL_CLK_50  = 2'h2
  } fll_clk_sel_e;

  // strap capture state
  typedef enum logic [1:0] {
    FLL_ST_CAPTURE = 2'b01,
    FLL_ST_RUN     = 2'b10
  } fll_state_e;

endpackage

// ===== fll_sync.sv
/*
  two-stage synchroniser for a group of level inputs.
  assumes inputs are quasi-static levels from pins outside the clock domain.
*/
`timescale 1ns/10ps
module fll_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    meta_reg <= din;
    dout     <= meta_reg;
  end

endmodule // fll_sync

// ===== fll_window_counter.sv
/*
  counts one kind of event inside a repeating observation window and pulses
  hit when the count reaches the threshold.
  assumes win_start is a one-cycle pulse on clk_sys opening each window.
*/
`timescale 1ns/10ps
module fll_window_counter #(
  parameter int THRESH = 20
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic enable,
  input  wire logic win_start,
  input  wire logic event_in,
  output logic      hit
);

  localparam logic [fll_pkg::CNT_W-1:0] THR = fll_pkg::CNT_W'(THRESH);

  logic [fll_pkg::CNT_W-1:0] cnt_reg;
  logic [fll_pkg::CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!enable || win_start) begin
      cnt_next = '0;
    end else if (event_in && cnt_reg != THR) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // pulse once, in the cycle the count first reaches the threshold
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hit <= 1'b0;
    end else begin
      hit <= enable && !win_start && event_in && (cnt_reg == THR - 1'b1);
    end
  end

endmodule // fll_window_counter

// ===== fll_top.sv
/*
  fast link-loss monitor with strap-sampled configuration latch.
  holds control_three, the fault status and the two link-drop config
  registers behind the management register port, watches receive-path
  events and drops the link when an enabled criterion is met.
  assumes receive-path events are on clk_sys; strap pins are asynchronous;
  srst is the power-up / hard reset, soft_reset a one-cycle pulse.
*/
//
// Behaviour
// - control_three bits 3:0 and 10 enable each link-loss criterion separately.
// - on a drop, the causing criteria are recorded in the readable status register.
// - rx error criterion drops link at 32 errors within one 10 us window.
// - code error criterion drops link at 20 errors within one 10 us window.
// - low snr criterion drops link at 20 crossings within one 10 us window.
// - energy criterion drops link as soon as energy loss is reported.
// - descrambler criterion drops link as soon as descrambler lock is lost.
// - criteria work singly or combined; any enabled one met drops the link.
// - strap levels are latched at power-up or hard reset and select modes.
// - soft reset restores strap settings from latched values without resampling.
// - every strap has two levels, default is the internal pull level.
// - enhanced mode builds the 3-bit management address from three straps.
// - interface strap selects mii at zero, rmii at one.
// - in mii mode a strap enables fast link loss at one.
// - in rmii mode a strap selects clock master at zero, slave at one.
// - in rmii mode a strap selects crs_dv at zero, pure rx_dv at one.
// - one strap enables auto crossover at zero; with it at one, another forces pair order.
// - strap enables autoneg at zero, at one disables it and forces 100M.
// - strap makes second led pin a 25 MHz clock at zero, led at one.
// - carrier-sense and collision clock outputs only in enhanced mode, 25 or 50 MHz.
`timescale 1ns/10ps
module fll_top (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        soft_reset,
  // management register port
  input  wire logic [15:0] mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  // receive-path events
  input  wire logic        rx_err_evt,
  input  wire logic        code_err_evt,
  input  wire logic        low_snr_evt,
  input  wire logic        energy_lost,
  input  wire logic        descr_locked,
  input  wire logic        link_restart,
  output logic             link_drop,
  output logic             link_down,
  // strap pins
  input  wire logic        enhanced_mode,
  input  wire logic        autoneg_select_pin,
  input  wire logic        addr_zero_select_pin,
  input  wire logic        addr_one_select_pin,
  input  wire logic        addr_two_select_pin,
  input  wire logic        rmii_clock_role_pin,
  input  wire logic        clock_or_led_select_pin,
  input  wire logic        link_loss_or_rx_qualifier_pin,
  input  wire logic        mac_interface_select_pin,
  input  wire logic        crossover_auto_pin,
  input  wire logic        pair_order_pin,
  input  wire logic [1:0]  clk_pin_request,
  // strap-derived configuration
  output logic      [2:0]  mgmt_phy_address,
  output logic             mac_is_rmii,
  output logic             rmii_clock_slave,
  output logic             rmii_rx_dv_only,
  output logic             auto_mdix_en,
  output logic             mdi_straight,
  output logic             autoneg_en,
  output logic             force_100,
  output logic             led1_is_reference_clock,
  output logic      [1:0]  clk_pin_select
);

  localparam int NSTRAP = 11;

  // decode shared by the write and read paths
  function automatic logic hit_addr(input logic [15:0] a, input logic [15:0] off);
    hit_addr = (a == off);
  endfunction

  logic [NSTRAP-1:0] strap_pins;
  logic [NSTRAP-1:0] strap_sync;
  logic [NSTRAP-1:0] strap_reg;
  fll_pkg::fll_state_e state_reg;
  logic [1:0]        cap_cnt_reg;
  logic [15:0]       control_three_reg;
  logic [15:0]       status_reg;
  logic [15:0]       config_one_reg;
  logic [15:0]       config_two_reg;
  logic [fll_pkg::WIN_W-1:0] win_cnt_reg;
  logic              win_start;
  logic [fll_pkg::NUM_COUNTED-1:0] cnt_hit;
  logic [fll_pkg::NUM_COUNTED-1:0] cnt_en;
  logic [fll_pkg::NUM_COUNTED-1:0] cnt_evt;
  logic              energy_prev_reg;
  logic              descr_prev_reg;
  logic              energy_trip;
  logic              descr_trip;
  logic [15:0]       cause;
  logic              drop_now;
  logic              loss_strap_en;
  logic [15:0]       ctl3_default;
  logic              status_read;

  // strap bit order in strap_reg
  assign strap_pins = {pair_order_pin, crossover_auto_pin, mac_interface_select_pin,
                       link_loss_or_rx_qualifier_pin, clock_or_led_select_pin,
                       rmii_clock_role_pin, addr_two_select_pin, addr_one_select_pin,
                       addr_zero_select_pin, autoneg_select_pin, enhanced_mode};

  fll_sync #(
    .W    (NSTRAP)
  ) u_strap_sync (
    .clk_sys (clk_sys),
    .din     (strap_pins),
    .dout    (strap_sync)
  );

  // capture straps while in reset and until the synchroniser has settled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg   <= fll_pkg::FLL_ST_CAPTURE;
      cap_cnt_reg <= fll_pkg::CAPTURE_CYC;
    end else begin
      case (state_reg)
        fll_pkg::FLL_ST_CAPTURE: begin
          if (cap_cnt_reg == 2'h0) begin
            state_reg <= fll_pkg::FLL_ST_RUN;
          end else begin
            cap_cnt_reg <= cap_cnt_reg - 1'b1;
          end
        end
        fll_pkg::FLL_ST_RUN: begin
          state_reg <= fll_pkg::FLL_ST_RUN;
        end
        default: begin
          state_reg <= fll_pkg::FLL_ST_CAPTURE;
        end
      endcase
    end
  end

  // latched only around hard reset; soft reset never resamples the pins
  always_ff @(posedge clk_sys) begin
    if (srst || state_reg == fll_pkg::FLL_ST_CAPTURE) begin
      strap_reg <= strap_sync;
    end
  end

  // strap decode
  assign mac_is_rmii   = strap_reg[8];
  assign loss_strap_en = !strap_reg[8] && strap_reg[7];
  assign ctl3_default  = loss_strap_en ? fll_pkg::CRIT_MASK : fll_pkg::CONTROL_THREE_RST;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mgmt_phy_address        <= fll_pkg::ADDR_STRAP_DEF;
      rmii_clock_slave        <= fll_pkg::STRAP_DEF_ZERO;
      rmii_rx_dv_only         <= fll_pkg::STRAP_DEF_ZERO;
      auto_mdix_en            <= 1'b1;
      mdi_straight            <= fll_pkg::STRAP_DEF_ZERO;
      autoneg_en              <= 1'b1;
      force_100               <= fll_pkg::STRAP_DEF_ZERO;
      led1_is_reference_clock <= 1'b1;
      clk_pin_select          <= fll_pkg::FLL_CLK_OFF;
    end else begin
      mgmt_phy_address        <= strap_reg[0] ? strap_reg[4:2]
                                              : fll_pkg::ADDR_STRAP_DEF;
      rmii_clock_slave        <= strap_reg[8] && strap_reg[5];
      rmii_rx_dv_only         <= strap_reg[8] && strap_reg[7];
      auto_mdix_en            <= !strap_reg[9];
      mdi_straight            <= strap_reg[9] && strap_reg[10];
      autoneg_en              <= !strap_reg[1];
      force_100               <= strap_reg[1];
      led1_is_reference_clock <= !strap_reg[6];
      if (strap_reg[0] && (clk_pin_request == fll_pkg::FLL_CLK_25 ||
                           clk_pin_request == fll_pkg::FLL_CLK_50)) begin
        clk_pin_select <= clk_pin_request;
      end else begin
        clk_pin_select <= fll_pkg::FLL_CLK_OFF;
      end
    end
  end

  // control_three: criterion enables, reloaded from straps on soft reset
  always_ff @(posedge clk_sys) begin
    if (srst || state_reg == fll_pkg::FLL_ST_CAPTURE || soft_reset) begin
      control_three_reg <= ctl3_default;
    end else if (mgmt_wr && hit_addr(mgmt_addr, fll_pkg::OFF_CONTROL_THREE)) begin
      control_three_reg <= mgmt_wdata;
    end
  end

  // link-drop config registers, plain storage for the receive path tuning
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      config_one_reg <= fll_pkg::CONFIG_ONE_RST;
      config_two_reg <= fll_pkg::CONFIG_TWO_RST;
    end else begin
      if (mgmt_wr && hit_addr(mgmt_addr, fll_pkg::OFF_CONFIG_ONE)) begin
        config_one_reg <= mgmt_wdata;
      end
      if (mgmt_wr && hit_addr(mgmt_addr, fll_pkg::OFF_CONFIG_TWO)) begin
        config_two_reg <= mgmt_wdata;
      end
    end
  end

  // shared observation window timer
  always_ff @(posedge clk_sys) begin
    if (srst || win_start) begin
      win_cnt_reg <= '0;
    end else begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
    end
  end

  assign win_start = (win_cnt_reg == fll_pkg::WIN_W'(fll_pkg::WINDOW_CYC - 1));

  assign cnt_en  = {control_three_reg[fll_pkg::BIT_SNR],
                    control_three_reg[fll_pkg::BIT_CODE],
                    control_three_reg[fll_pkg::BIT_RX_ERR]} & {3{!link_down}};
  assign cnt_evt = {low_snr_evt, code_err_evt, rx_err_evt};

  localparam int THR_TAB [fll_pkg::NUM_COUNTED] = '{fll_pkg::THR_RX_ERR,
                                                    fll_pkg::THR_CODE,
                                                    fll_pkg::THR_SNR};

  generate
    for (genvar i = 0; i < fll_pkg::NUM_COUNTED; i++) begin : g_crit
      fll_window_counter #(
        .THRESH (THR_TAB[i])
      ) u_cnt (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .enable    (cnt_en[i]),
        .win_start (win_start),
        .event_in  (cnt_evt[i]),
        .hit       (cnt_hit[i])
      );
    end
  endgenerate

  // edge detect for the level criteria
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // idle levels: energy present, descrambler locked, so no false edge after reset
      energy_prev_reg <= 1'b0;
      descr_prev_reg  <= 1'b1;
    end else begin
      energy_prev_reg <= energy_lost;
      descr_prev_reg  <= descr_locked;
    end
  end

  assign energy_trip = control_three_reg[fll_pkg::BIT_ENERGY] && energy_lost
                       && !energy_prev_reg;
  assign descr_trip  = control_three_reg[fll_pkg::BIT_DESCR] && !descr_locked
                       && descr_prev_reg;

  always_comb begin
    cause = '0;
    // a hit registered in the drop cycle must not cause a second drop
    cause[fll_pkg::BIT_RX_ERR] = cnt_hit[0] && !link_down;
    cause[fll_pkg::BIT_CODE]   = cnt_hit[1] && !link_down;
    cause[fll_pkg::BIT_SNR]    = cnt_hit[2] && !link_down;
    cause[fll_pkg::BIT_ENERGY] = energy_trip && !link_down;
    cause[fll_pkg::BIT_DESCR]  = descr_trip && !link_down;
  end

  assign drop_now = |cause;

  // drop pulse and held link-down level until the link restarts
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      link_drop <= 1'b0;
      link_down <= 1'b0;
    end else begin
      link_drop <= drop_now;
      if (drop_now) begin
        link_down <= 1'b1;
      end else if (link_restart) begin
        link_down <= 1'b0;
      end
    end
  end

  assign status_read = mgmt_rd && hit_addr(mgmt_addr, fll_pkg::OFF_FAULT_STATUS);

  // sticky causes, cleared by reading; a new cause in the read cycle survives
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      status_reg <= fll_pkg::FAULT_STATUS_RST;
    end else if (status_read) begin
      status_reg <= cause;
    end else begin
      status_reg <= status_reg | cause;
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mgmt_rdata  <= '0;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (!mgmt_rd) begin
        mgmt_rdata <= mgmt_rdata;
      end else if (hit_addr(mgmt_addr, fll_pkg::OFF_CONTROL_THREE)) begin
        mgmt_rdata <= control_three_reg;
      end else if (status_read) begin
        mgmt_rdata <= status_reg | cause;
      end else if (hit_addr(mgmt_addr, fll_pkg::OFF_CONFIG_ONE)) begin
        mgmt_rdata <= config_one_reg;
      end else if (hit_addr(mgmt_addr, fll_pkg::OFF_CONFIG_TWO)) begin
        mgmt_rdata <= config_two_reg;
      end else begin
        mgmt_rdata <= '0;
      end
    end
  end

endmodule // fll_top

// ===== fll_top_assertions.sv
/*
  checker for fll_top: link-drop and strap-decode relations at the ports.
  assumes it is bound to fll_top, one clk_sys domain, srst active high.
*/
`timescale 1ns/10ps
module fll_top_assertions (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       soft_reset,
  input wire logic       link_restart,
  input wire logic       rx_err_evt,
  input wire logic       code_err_evt,
  input wire logic       low_snr_evt,
  input wire logic       energy_lost,
  input wire logic       descr_locked,
  input wire logic       link_drop,
  input wire logic       link_down,
  input wire logic       enhanced_mode,
  input wire logic [2:0] mgmt_phy_address,
  input wire logic       mac_is_rmii,
  input wire logic       rmii_clock_slave,
  input wire logic       auto_mdix_en,
  input wire logic       mdi_straight,
  input wire logic       autoneg_en,
  input wire logic       force_100,
  input wire logic [1:0] clk_pin_select
);
  // any receive-path condition that may justify a drop
  wire logic cause = rx_err_evt | code_err_evt | low_snr_evt | energy_lost | ~descr_locked;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_drop_cause:
    assert property (link_drop |-> $past(cause) || $past(cause, 2))
    else $error("link drop without a receive-path cause");
  chk_drop_sets_down:
    assert property (link_drop |-> link_down)
    else $error("link drop without link down");
  chk_down_holds:
    assert property (link_down && !link_restart && !soft_reset |=> link_down)
    else $error("link down released without restart");
  chk_no_redrop:
    assert property (link_down && !link_restart |=> !link_drop)
    else $error("second drop while link is down");
  chk_addr_enhanced:
    assert property (mgmt_phy_address != 3'h0 |-> enhanced_mode)
    else $error("address straps used outside enhanced mode");
  chk_clk_pins:
    assert property (clk_pin_select != 2'h0 |-> enhanced_mode && clk_pin_select != 2'h3)
    else $error("clock pin output outside enhanced mode or bad rate");
  chk_autoneg_force:
    assert property (autoneg_en != force_100)
    else $error("autoneg and forced speed disagree");
  chk_mdix_order:
    assert property (mdi_straight |-> !auto_mdix_en)
    else $error("pair order forced while auto crossover on");
  chk_rmii_role:
    assert property (rmii_clock_slave |-> mac_is_rmii)
    else $error("clock role set outside rmii mode");
  chk_soft_keeps:
    assert property (soft_reset |=> $stable({mgmt_phy_address, mac_is_rmii, autoneg_en}))
    else $error("soft reset changed strap settings");

  cov_drop: cover property (link_drop);
  cov_soft: cover property (soft_reset);
  cov_straight: cover property (mdi_straight);
endmodule // fll_top_assertions

// ===== fll_link_partner.sv
/*
  receive-path model of the far side: event pulses and line levels.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
module fll_link_partner (
  input  wire logic clk_sys,
  output logic      rx_err_evt,
  output logic      code_err_evt,
  output logic      low_snr_evt,
  output logic      energy_lost,
  output logic      descr_locked
);
  initial begin
    {rx_err_evt, code_err_evt, low_snr_evt, energy_lost} = 4'h0;
    descr_locked = 1'b1;
  end
  // n back-to-back event cycles; kind 0 rx error, 1 code error, 2 low snr
  task automatic burst(input int kind, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      rx_err_evt = (kind == 0);
      code_err_evt = (kind == 1);
      low_snr_evt = (kind == 2);
    end
    @(negedge clk_sys);
    {rx_err_evt, code_err_evt, low_snr_evt} = 3'h0;
  endtask
  task automatic line(input logic lost, input logic locked);
    @(negedge clk_sys);
    energy_lost = lost;
    descr_locked = locked;
  endtask
endmodule // fll_link_partner

// ===== tb_fll_top.sv
/*
  self-checking bench for fll_top: straps, registers, link-drop criteria.
  assumes fll_link_partner drives the receive path; window is 400 cycles.
*/
`timescale 1ns/10ps
module tb_fll_top;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        soft_reset = 1'b0;
  logic        link_restart = 1'b0;
  logic        mgmt_wr = 1'b0;
  logic        mgmt_rd = 1'b0;
  logic [15:0] mgmt_addr = 16'h0000;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] rnd = 16'h4609;
  logic [15:0] d;
  logic [12:0] strap = 13'h0000;
  wire  [12:0] outv;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid, link_drop, link_down;
  logic        rx_err_evt, code_err_evt, low_snr_evt, energy_lost, descr_locked;
  logic [15:0] ofs[3] = '{fll_pkg::OFF_CONTROL_THREE, fll_pkg::OFF_CONFIG_ONE,
                          fll_pkg::OFF_CONFIG_TWO};
  int          bp[3] = '{fll_pkg::BIT_RX_ERR, fll_pkg::BIT_CODE, fll_pkg::BIT_SNR};
  int          th[3] = '{fll_pkg::THR_RX_ERR, fll_pkg::THR_CODE, fll_pkg::THR_SNR};
  int          checks = 0;
  int          miscompares = 0;
  int          drops = 0;
  int          exp_drops = 0;
  int          win_ph = 0;

  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (link_drop === 1'b1) drops <= drops + 1;
  // window phase model: free-running from reset, restarts every window
  always @(posedge clk_sys) begin
    win_ph <= (srst || win_ph == fll_pkg::WINDOW_CYC - 1) ? 0 : win_ph + 1;
  end

  fll_top fll_top_i (
    .clk_sys(clk_sys), .srst(srst), .soft_reset(soft_reset), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .rx_err_evt(rx_err_evt),
    .code_err_evt(code_err_evt), .low_snr_evt(low_snr_evt), .energy_lost(energy_lost),
    .descr_locked(descr_locked), .link_restart(link_restart), .link_drop(link_drop),
    .link_down(link_down), .enhanced_mode(strap[12]), .clk_pin_request(strap[11:10]),
    .autoneg_select_pin(strap[9]), .addr_zero_select_pin(strap[8]),
    .addr_one_select_pin(strap[7]), .addr_two_select_pin(strap[6]),
    .rmii_clock_role_pin(strap[5]), .clock_or_led_select_pin(strap[4]),
    .link_loss_or_rx_qualifier_pin(strap[3]), .mac_interface_select_pin(strap[2]),
    .crossover_auto_pin(strap[1]), .pair_order_pin(strap[0]),
    .mgmt_phy_address(outv[12:10]), .mac_is_rmii(outv[9]), .rmii_clock_slave(outv[8]),
    .rmii_rx_dv_only(outv[7]), .auto_mdix_en(outv[6]), .mdi_straight(outv[5]),
    .autoneg_en(outv[4]), .force_100(outv[3]), .led1_is_reference_clock(outv[2]),
    .clk_pin_select(outv[1:0])
  );
  fll_link_partner fll_link_partner_i (
    .clk_sys(clk_sys), .rx_err_evt(rx_err_evt), .code_err_evt(code_err_evt),
    .low_snr_evt(low_snr_evt), .energy_lost(energy_lost), .descr_locked(descr_locked)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected decoded outputs for a strap vector, same order as outv
  function automatic logic [12:0] expv(input logic [12:0] s);
    logic [1:0] q;
    q = s[11:10];
    return {s[12] ? {s[6], s[7], s[8]} : 3'h0, s[2], s[2] & s[5], s[2] & s[3], ~s[1],
            s[1] & s[0], ~s[9], s[9], ~s[4], (s[12] && (q == 2'h1 || q == 2'h2)) ? q : 2'h0};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rst(input logic [12:0] s);
    @(negedge clk_sys);
    srst = 1'b1;
    strap = s;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk_sys);
    mgmt_addr = a;
    mgmt_wdata = v;
    mgmt_wr = 1'b1;
    @(negedge clk_sys);
    mgmt_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk_sys);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk_sys);
    mgmt_rd = 1'b0;
    check(mgmt_rvalid, 1'b1);
    d = mgmt_rdata;
  endtask
  task automatic settle_drops();
    repeat (3) @(negedge clk_sys);
    check(drops, exp_drops[15:0]);
  endtask

  // whole run is a few thousand cycles
  initial begin
    #500000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      rst(i == 0 ? 13'h0000 : rnd[12:0]);
      check(outv, expv(strap));
      rd(fll_pkg::OFF_CONTROL_THREE);
      check(d, (!strap[2] && strap[3]) ? fll_pkg::CRIT_MASK : 16'h0000);
    end
    rst(13'h0000);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      wr(ofs[i % 3], (i % 3 == 0) ? rnd & fll_pkg::CRIT_MASK : rnd);
      rd(ofs[i % 3]);
      check(d, (i % 3 == 0) ? rnd & fll_pkg::CRIT_MASK : rnd);
    end
    wr(fll_pkg::OFF_FAULT_STATUS, 16'hffff);
    rd(fll_pkg::OFF_FAULT_STATUS);
    check(d, 16'h0000);
    rd(16'h0005);
    check(d, 16'h0000);
    // soft reset must reload from latched straps, not the changed pins
    rst(13'h0008);
    wr(fll_pkg::OFF_CONTROL_THREE, 16'h0000);
    strap = 13'h0ff7;
    @(negedge clk_sys);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(outv, expv(13'h0008));
    rd(fll_pkg::OFF_CONTROL_THREE);
    check(d, fll_pkg::CRIT_MASK);
    for (int k = 0; k < 3; k++) begin
      rst(13'h0000);
      wr(fll_pkg::OFF_CONFIG_ONE, 16'h0417);
      wr(fll_pkg::OFF_CONTROL_THREE, 16'h0001 << bp[k]);
      fll_link_partner_i.burst((k + 1) % 3, 32);
      fll_link_partner_i.burst(k, th[k] - 1);
      settle_drops();
      repeat (fll_pkg::WINDOW_CYC) @(negedge clk_sys);
      // start the burst just after a window opens so it fits inside one window
      while (win_ph != 0) @(negedge clk_sys);
      fll_link_partner_i.burst(k, th[k]);
      exp_drops++;
      settle_drops();
      rd(fll_pkg::OFF_FAULT_STATUS);
      check(d, 16'h0001 << bp[k]);
    end
    rst(13'h0000);
    wr(fll_pkg::OFF_CONFIG_TWO, 16'h0008);
    wr(fll_pkg::OFF_CONTROL_THREE, fll_pkg::CRIT_MASK);
    fll_link_partner_i.line(1'b1, 1'b1);
    exp_drops++;
    settle_drops();
    check(link_down, 1'b1);
    rd(fll_pkg::OFF_FAULT_STATUS);
    check(d, 16'h0001 << fll_pkg::BIT_ENERGY);
    link_restart = 1'b1;
    @(negedge clk_sys);
    link_restart = 1'b0;
    @(negedge clk_sys);
    check(link_down, 1'b0);
    fll_link_partner_i.line(1'b0, 1'b0);
    exp_drops++;
    settle_drops();
    rd(fll_pkg::OFF_FAULT_STATUS);
    check(d, 16'h0001 << fll_pkg::BIT_DESCR);
    close_out();
  end
endmodule // tb_fll_top

bind fll_top fll_top_assertions fll_top_assertions_i (
  .clk_sys(clk_sys), .srst(srst), .soft_reset(soft_reset), .link_restart(link_restart),
  .rx_err_evt(rx_err_evt), .code_err_evt(code_err_evt), .low_snr_evt(low_snr_evt),
  .energy_lost(energy_lost), .descr_locked(descr_locked), .link_drop(link_drop),
  .link_down(link_down), .enhanced_mode(enhanced_mode), .mgmt_phy_address(mgmt_phy_address),
  .mac_is_rmii(mac_is_rmii), .rmii_clock_slave(rmii_clock_slave),
  .auto_mdix_en(auto_mdix_en), .mdi_straight(mdi_straight), .autoneg_en(autoneg_en),
  .force_100(force_100), .clk_pin_select(clk_pin_select)
);
